// file: rtl/ict_decode.sv
// instruction word decode and cycle timing sequencer
`timescale 1ns/1ns
module ict_decode
  import ict_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        clkEn,
  input  wire logic [23:0] fetchWord,
  input  wire logic        fetchValid,
  input  wire logic [23:0] nextWord,
  input  wire logic        condTrue,
  input  wire logic        flagWe,
  input  wire logic        resCarry,
  input  wire logic        resDigitCarry,
  input  wire logic        resNeg,
  input  wire logic        resOverflow,
  input  wire logic        resZero,
  input  wire logic        stickyZ,
  output logic             fetchReady,
  output logic             pcAdvance,
  output logic [1:0]       pcAdvanceWords,
  output logic             execValid,
  output ict_class_t       execClass,
  output logic [47:0]      execWord,
  output logic             nopSlot,
  output logic             illegalOp,
  output logic [3:0]       bitSelectorField,
  output logic [12:0]      fileAddr,
  output logic [15:0]      litValue,
  output logic             accSel,
  output logic             accWritebackDest,
  output logic [3:0]       workRegIdx,
  output logic [22:0]      programAddressLiteral,
  output logic             carryFlag,
  output logic             digitCarryFlag,
  output logic             negFlag,
  output logic             overflowFlag,
  output logic             zeroFlag
);

  typedef struct packed {
    ict_state_t st;
    logic [1:0]  fillCnt;
    logic [1:0]  advWords;
    logic [23:0] word1;
    logic        fetchReady;
    logic        pcAdvance;
    logic [1:0]  pcAdvanceWords;
    logic        execValid;
    ict_class_t  execClass;
    logic [47:0] execWord;
    logic        nopSlot;
    logic        illegalOp;
    logic [3:0]  bitSel;
    logic [12:0] fileAddr;
    logic [15:0] litValue;
    logic        accSel;
    logic        accWb;
    logic [3:0]  workRegIdx;
    logic [22:0] progAddr;
    logic        fCarry;
    logic        fDigitCarry;
    logic        fNeg;
    logic        fOverflow;
    logic        fZero;
  } ict_regs_t;

  localparam ict_regs_t RST = '{
    st:         ST_EXEC,
    execClass:  CLS_NOP,
    fetchReady: 1'b1,
    default:    '0
  };

  ict_regs_t  r;
  ict_regs_t  n;

  ict_class_t curClass;
  ict_class_t nextClass;
  logic [2:0] curLitSel;
  logic [2:0] unusedLitSel;
  logic [3:0] xBitSel;
  logic [12:0] xFileAddr;
  logic [15:0] xLitValue;
  logic       xAccSel;
  logic       xAccWb;
  logic [3:0] xWorkReg;
  logic       take;
  logic       nextIsDouble;
  logic [1:0] extra;
  logic [22:0] dblAddr;

  ict_op_class u_cur_class (
    .opcode  (fetchWord[OPC_MSB:OPC_LSB]),
    .opClass (curClass),
    .litSel  (curLitSel)
  );

  // lookahead on the word after a skip decides how much it hides
  ict_op_class u_next_class (
    .opcode  (nextWord[OPC_MSB:OPC_LSB]),
    .opClass (nextClass),
    .litSel  (unusedLitSel)
  );

  ict_field_extract u_fields (
    .word             (fetchWord),
    .litSel           (curLitSel),
    .bitSelectorField (xBitSel),
    .fileAddr         (xFileAddr),
    .litValue         (xLitValue),
    .accSel           (xAccSel),
    .accWritebackDest (xAccWb),
    .workRegIdx       (xWorkReg)
  );

  assign nextIsDouble = (nextClass == CLS_DOUBLE);
  // address literal: low 16 bits in word one, upper 7 in word two
  assign dblAddr = {fetchWord[6:0], r.word1[15:0]};

  always_comb begin
    n = r;
    take = 1'b0;
    extra = 2'h0;
    case (curClass)
      CLS_COND:     extra = condTrue ? CYC_COND_TRUE - 2'h1 : 2'h0;
      CLS_SKIP: begin
        if (condTrue) begin
          extra = (nextIsDouble ? CYC_SKIP_DBL : CYC_SKIP_SGL) - 2'h1;
        end
      end
      CLS_BRANCH:   extra = CYC_BRANCH - 2'h1;
      CLS_INDIRECT: extra = CYC_INDIRECT - 2'h1;
      CLS_TABLE:    extra = CYC_TABLE - 2'h1;
      CLS_RETURN:   extra = CYC_RETURN - 2'h1;
      CLS_DMOVE:    extra = CYC_DMOVE - 2'h1;
      default:      extra = 2'h0;
    endcase
    if (clkEn) begin
      n.execValid = 1'b0;
      n.pcAdvance = 1'b0;
      n.nopSlot   = 1'b0;
      n.illegalOp = 1'b0;
      // flags move only on a real execute cycle, never on a filler
      if (r.execValid && flagWe && r.execClass != CLS_NOP) begin
        n.fCarry      = resCarry;
        n.fDigitCarry = resDigitCarry;
        n.fNeg        = resNeg;
        n.fOverflow   = resOverflow;
        // sticky mode can only clear zero, so multi-word compares chain
        n.fZero = stickyZ ? (r.fZero & resZero) : resZero;
      end
      case (r.st)
        ST_EXEC: begin
          if (fetchValid) begin
            take = 1'b1;
            n.pcAdvanceWords = 2'h1;
            if (curClass == CLS_DOUBLE) begin
              n.word1     = fetchWord;
              n.st        = ST_WORD2;
              n.pcAdvance = 1'b1;
            end else begin
              n.execValid  = 1'b1;
              n.execClass  = curClass;
              n.execWord   = {24'h000000, fetchWord};
              n.bitSel     = xBitSel;
              n.fileAddr   = xFileAddr;
              n.litValue   = xLitValue;
              n.accSel     = xAccSel;
              n.accWb      = xAccWb;
              n.workRegIdx = xWorkReg;
              if (extra == 2'h0) begin
                n.pcAdvance = 1'b1;
              end else begin
                // hold fetch until the filler cycles are done
                n.st         = ST_FILL;
                n.fetchReady = 1'b0;
                n.fillCnt    = extra;
                n.advWords   = (curClass == CLS_SKIP) ? extra + 2'h1 : 2'h1;
              end
            end
          end
        end
        ST_WORD2: begin
          if (fetchValid) begin
            take = 1'b1;
            n.st = ST_EXEC;
            n.pcAdvance = 1'b1;
            n.pcAdvanceWords = 2'h1;
            // a malformed pair is dropped rather than executed half-decoded
            if (fetchWord[OPC_MSB:OPC_LSB] != 8'h00 || dblAddr[0]) begin
              n.illegalOp = 1'b1;
            end else begin
              n.execValid = 1'b1;
              n.execClass = CLS_DOUBLE;
              n.execWord  = {r.word1, fetchWord};
              n.progAddr  = dblAddr;
              n.fileAddr  = r.word1[FADDR_W-1:0];
              n.litValue  = r.word1[15:0];
            end
          end
        end
        ST_FILL: begin
          n.nopSlot = 1'b1;
          n.fillCnt = r.fillCnt - 2'h1;
          if (r.fillCnt == 2'h1) begin
            n.st             = ST_EXEC;
            n.fetchReady     = 1'b1;
            n.pcAdvance      = 1'b1;
            n.pcAdvanceWords = r.advWords;
          end
        end
        default: begin
          n.st         = ST_EXEC;
          n.fetchReady = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  assign fetchReady            = r.fetchReady;
  assign pcAdvance             = r.pcAdvance;
  assign pcAdvanceWords        = r.pcAdvanceWords;
  assign execValid             = r.execValid;
  assign execClass             = r.execClass;
  assign execWord              = r.execWord;
  assign nopSlot               = r.nopSlot;
  assign illegalOp             = r.illegalOp;
  assign bitSelectorField      = r.bitSel;
  assign fileAddr              = r.fileAddr;
  assign litValue              = r.litValue;
  assign accSel                = r.accSel;
  assign accWritebackDest      = r.accWb;
  assign workRegIdx            = r.workRegIdx;
  assign programAddressLiteral = r.progAddr;
  assign carryFlag             = r.fCarry;
  assign digitCarryFlag        = r.fDigitCarry;
  assign negFlag               = r.fNeg;
  assign overflowFlag          = r.fOverflow;
  assign zeroFlag              = r.fZero;

  // timing checks assume the clock enable stays high
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn || !clkEn);

  fill_is_nop_a: assert property (
    nopSlot |-> !execValid && !illegalOp
  ) else $error("filler cycle carries an execute");

  // the last filler reopens fetch in the same cycle that the PC moves
  fill_stalls_a: assert property (
    nopSlot |-> (fetchReady == pcAdvance) && (pcAdvance == (r.st == ST_EXEC))
  ) else $error("fetch or PC moved during filler");

  cond_true_a: assert property (
    (take && r.st == ST_EXEC && curClass == CLS_COND && condTrue)
      |=> execValid ##1 (nopSlot && pcAdvance) ##1 fetchReady
  ) else $error("true conditional not two cycles");

  single_one_a: assert property (
    (take && r.st == ST_EXEC && curClass == CLS_NORMAL)
      |=> execValid && pcAdvance && fetchReady
  ) else $error("plain instruction not one cycle");

  return_three_a: assert property (
    (take && r.st == ST_EXEC && curClass == CLS_RETURN)
      |=> execValid ##1 nopSlot [*2] ##1 (!nopSlot && fetchReady)
  ) else $error("return not three cycles");

  skip_words_a: assert property (
    (take && r.st == ST_EXEC && curClass == CLS_SKIP && condTrue && nextIsDouble)
      |=> ##2 (nopSlot && pcAdvance && pcAdvanceWords == 2'h3)
  ) else $error("skip over double word not three cycles");

  double_two_a: assert property (
    (take && r.st == ST_EXEC && curClass == CLS_DOUBLE)
      ##1 fetchValid |=> (execValid || illegalOp) && fetchReady
  ) else $error("double word not two cycles");

  word2_zero_a: assert property (
    (execValid && execClass == CLS_DOUBLE)
      |-> execWord[OPC_MSB:OPC_LSB] == 8'h00 && !programAddressLiteral[0]
  ) else $error("bad second word executed");

  lone_word2_a: assert property (
    (take && r.st == ST_EXEC && fetchWord[OPC_MSB:OPC_LSB] == 8'h00)
      |=> execValid && execClass == CLS_NOP && !nopSlot
  ) else $error("lone second word not a no-operation");

  zero_sticky_a: assert property (
    (execValid && execClass != CLS_NOP && flagWe && stickyZ && !zeroFlag)
      |=> !zeroFlag
  ) else $error("sticky zero was set");

  default_default_working_reg_a: assert property (
    (take && r.st == ST_EXEC && fetchWord[DEFAULT_WORKING_REG_BIT] && curClass == CLS_NORMAL)
      |=> workRegIdx == DEFAULT_DEFAULT_WORKING_REG_IDX
  ) else $error("default register not W0");

  branch_two_a: assert property (
    (take && r.st == ST_EXEC && curClass inside {CLS_BRANCH, CLS_INDIRECT, CLS_TABLE})
      |=> (execValid && !fetchReady) ##1 (nopSlot && pcAdvance && fetchReady)
  ) else $error("branch class not two cycles");

  dmove_two_a: assert property (
    (take && r.st == ST_EXEC && curClass == CLS_DMOVE)
      |=> (execValid && !fetchReady) ##1 (nopSlot && pcAdvance && fetchReady)
  ) else $error("double move not two cycles");

  skip_single_a: assert property (
    (take && r.st == ST_EXEC && curClass == CLS_SKIP && condTrue && !nextIsDouble)
      |=> execValid ##1 (nopSlot && pcAdvance && pcAdvanceWords == 2'h2)
  ) else $error("skip over single word not two cycles");

  skip_miss_a: assert property (
    (take && r.st == ST_EXEC && curClass == CLS_SKIP && !condTrue)
      |=> execValid && pcAdvance && pcAdvanceWords == 2'h1
  ) else $error("untaken skip not one cycle");

  bad_pair_a: assert property (
    illegalOp |-> !execValid && pcAdvance && fetchReady
  ) else $error("malformed pair was executed");

  issue_stall_a: assert property (
    execValid |-> (pcAdvance == fetchReady)
  ) else $error("issue neither done nor stalled");

  nop_flags_a: assert property (
    (execValid && execClass == CLS_NOP)
      |=> $stable({carryFlag, digitCarryFlag, negFlag, overflowFlag, zeroFlag})
  ) else $error("no-operation changed flags");

  fill_flags_a: assert property (
    nopSlot |=> $stable({carryFlag, digitCarryFlag, negFlag, overflowFlag, zeroFlag})
  ) else $error("filler cycle changed flags");

  multi_advance_a: assert property (
    (pcAdvance && pcAdvanceWords != 2'h1) |-> nopSlot
  ) else $error("multi word advance outside a skip fill");

endmodule // ict_decode

// file: rtl/ict_field_extract.sv
// operand field extraction from one instruction word
`timescale 1ns/1ns
module ict_field_extract
  import ict_pkg::*;
(
  input  wire logic [23:0] word,
  input  wire logic [2:0]  litSel,
  output logic [3:0]       bitSelectorField,
  output logic [12:0]      fileAddr,
  output logic [15:0]      litValue,
  output logic             accSel,
  output logic             accWritebackDest,
  output logic [3:0]       workRegIdx
);

  assign bitSelectorField = word[BITSEL_MSB:BITSEL_LSB];
  assign fileAddr         = word[FADDR_W-1:0];
  assign accSel           = word[ACCSEL_BIT];
  assign accWritebackDest = word[ACCWB_BIT];
  // default register bit overrides the encoded register
  assign workRegIdx = word[DEFAULT_WORKING_REG_BIT] ? DEFAULT_DEFAULT_WORKING_REG_IDX : word[3:0];

  always_comb begin
    case (litSel)
      LIT_1:   litValue = {15'h0000, word[0]};
      LIT_4:   litValue = {12'h000, word[3:0]};
      LIT_5:   litValue = {11'h000, word[4:0]};
      LIT_8:   litValue = {8'h00, word[7:0]};
      LIT_14:  litValue = {2'h0, word[13:0]};
      default: litValue = word[15:0];
    endcase
  end

endmodule // ict_field_extract

// file: rtl/ict_op_class.sv
// opcode to instruction class and literal width lookup
`timescale 1ns/1ns
module ict_op_class
  import ict_pkg::*;
(
  input  wire logic [7:0] opcode,
  output ict_class_t      opClass,
  output logic [2:0]      litSel
);

  always_comb begin
    litSel = opcode[2:0];
    case (opcode)
      OPC_NOP:                      opClass = CLS_NOP;
      OPC_BRANCH_COND:              opClass = CLS_COND;
      OPC_SKIP:                     opClass = CLS_SKIP;
      OPC_BRANCH:                   opClass = CLS_BRANCH;
      OPC_CALL_IND, OPC_JUMP_IND:   opClass = CLS_INDIRECT;
      OPC_TBL_RD, OPC_TBL_WR:       opClass = CLS_TABLE;
      OPC_RETURN,
      OPC_INTERRUPT_RETURN:         opClass = CLS_RETURN;
      OPC_DMOVE:                    opClass = CLS_DMOVE;
      OPC_CALL_ABS, OPC_JUMP_ABS:   opClass = CLS_DOUBLE;
      default:                      opClass = CLS_NORMAL;
    endcase
  end

endmodule // ict_op_class

// file: rtl/ict_pkg.sv
// constants, classes and state types for the instruction cycle timing decoder
// Summary of operation
// - a single word is 24 bits, its top 8 bits select the instruction type
// - double-word instructions gather two consecutive words into one 48-bit field
// - the second word of a double-word instruction has its top 8 bits zero
// - a lone second word executes as a no-operation without side effects
// - single words take one cycle, two or three when a test is true or PC changes
// - every extra cycle is a no-operation that changes no state
// - branch, indirect call/jump, table access and returns take two or three cycles
// - a taken skip costs two cycles over one word, three over two words
// - double-word data moves take two cycles
// - every double-word instruction executes in exactly two cycles
// - the bit selector is a 4-bit field picking bit 0 to 15
// - the file register address spans 0 to 0x1FFF
// - the accumulator select picks exactly one of accumulators A or B
// - write-back goes to W13 direct or to [W13] post-incremented by two
// - unsigned literals of 1, 4, 5, 8, 14, 16 bits are zero-extended
// - program address literals are 23 bits with least significant bit zero
// - carry, digit carry, negative, overflow and sticky zero flags are kept
// - file register instructions naming the default register use W0
package ict_pkg;

  localparam int INSTR_W = 24;
  localparam int OPC_W   = 8;
  localparam int OPC_MSB = 23;
  localparam int OPC_LSB = 16;
  localparam int DBL_W   = 48;

  localparam int BITSEL_MSB = 15;
  localparam int BITSEL_LSB = 12;
  localparam int FADDR_W    = 13;
  localparam logic [12:0] FADDR_MAX = 13'h1FFF;
  localparam int ACCSEL_BIT = 15;
  localparam int ACCWB_BIT  = 14;
  localparam int DEFAULT_WORKING_REG_BIT   = 13;
  localparam int PADDR_W    = 23;

  localparam logic [3:0] DEFAULT_DEFAULT_WORKING_REG_IDX = 4'h0;
  localparam logic [3:0] WB_REG_IDX       = 4'hD;
  localparam logic [1:0] WB_POST_INC      = 2'h2;

  // literal width codes carried in the low opcode bits
  localparam logic [2:0] LIT_16 = 3'h0;
  localparam logic [2:0] LIT_1  = 3'h1;
  localparam logic [2:0] LIT_4  = 3'h2;
  localparam logic [2:0] LIT_5  = 3'h3;
  localparam logic [2:0] LIT_8  = 3'h4;
  localparam logic [2:0] LIT_14 = 3'h5;

  localparam logic [7:0] OPC_NOP              = 8'h00;
  localparam logic [7:0] OPC_BRANCH_COND      = 8'h31;
  localparam logic [7:0] OPC_BRANCH           = 8'h37;
  localparam logic [7:0] OPC_CALL_IND         = 8'h01;
  localparam logic [7:0] OPC_JUMP_IND         = 8'h03;
  localparam logic [7:0] OPC_TBL_RD           = 8'hBA;
  localparam logic [7:0] OPC_TBL_WR           = 8'hBB;
  localparam logic [7:0] OPC_RETURN           = 8'h06;
  localparam logic [7:0] OPC_INTERRUPT_RETURN = 8'h07;
  localparam logic [7:0] OPC_SKIP             = 8'hE6;
  localparam logic [7:0] OPC_DMOVE            = 8'hBE;
  localparam logic [7:0] OPC_CALL_ABS         = 8'h02;
  localparam logic [7:0] OPC_JUMP_ABS         = 8'h04;

  // total cycles per class
  localparam logic [1:0] CYC_COND_TRUE = 2'h2;
  localparam logic [1:0] CYC_BRANCH    = 2'h2;
  localparam logic [1:0] CYC_INDIRECT  = 2'h2;
  localparam logic [1:0] CYC_TABLE     = 2'h2;
  localparam logic [1:0] CYC_RETURN    = 2'h3;
  localparam logic [1:0] CYC_DMOVE     = 2'h2;
  localparam logic [1:0] CYC_SKIP_SGL  = 2'h2;
  localparam logic [1:0] CYC_SKIP_DBL  = 2'h3;

  typedef enum logic [3:0] {
    CLS_NOP, CLS_NORMAL, CLS_COND, CLS_SKIP, CLS_BRANCH,
    CLS_INDIRECT, CLS_TABLE, CLS_RETURN, CLS_DMOVE, CLS_DOUBLE
  } ict_class_t;

  typedef enum logic [2:0] {
    ST_EXEC  = 3'b001,
    ST_WORD2 = 3'b010,
    ST_FILL  = 3'b100
  } ict_state_t;

endpackage

// file: verification/ict_fetch_model.sv
// fetch unit model presenting instruction words to the decoder
`timescale 1ns/1ns
module ict_fetch_model (
  input  wire logic        ref_clk,
  input  wire logic        fetchReady,
  output logic [23:0]      fetchWord,
  output logic             fetchValid,
  output logic [23:0]      nextWord
);
  logic [23:0] lastWord;

  initial begin
    fetchWord = 24'h000000;
    fetchValid = 1'b0;
    nextWord = 24'h000000;
    lastWord = 24'h000000;
  end

  // word stands from a falling edge until a rising edge that sees ready high
  task automatic present(input logic [23:0] w, input logic [23:0] nx);
    int n;
    begin
      n = 0;
      fetchWord = w;
      nextWord = nx;
      fetchValid = 1'b1;
      @(posedge ref_clk);
      while (fetchReady !== 1'b1 && n < 16) begin
        n++;
        @(posedge ref_clk);
      end
      // a decoder that never takes the word ends the run as a failure
      if (n == 16) begin
        tb_top.fails++;
        tb_top.tally_and_finish();
      end
      lastWord = w;
      @(negedge ref_clk);
    end
  endtask

  // inverse of the old word, so a stale word never passes for a fresh one
  task automatic release_bus();
    fetchValid = 1'b0;
    fetchWord = ~lastWord;
    nextWord = ~nextWord;
  endtask
endmodule // ict_fetch_model

// file: verification/tb_top.sv
// self-checking bench for the instruction cycle timing decoder
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top
  import ict_pkg::*;
;
  typedef struct packed {
    logic [23:0] w;
    logic        ct;
    logic [23:0] nx;
    ict_class_t  cls;
    logic [3:0]  cyc;
    logic [1:0]  wds;
  } ict_row_t;
  typedef struct packed {
    logic [4:0] r;
    logic       s;
    logic [7:0] op;
    logic [4:0] e;
  } ict_flag_t;

  localparam ict_row_t ROWS [15] = '{
    '{24'h100000, 1'b0, 24'h0, CLS_NORMAL, 4'h1, 2'h1},
    '{24'h310000, 1'b0, 24'h0, CLS_COND, 4'h1, 2'h1},
    '{24'h310000, 1'b1, 24'h0, CLS_COND, 4'h2, 2'h1},
    '{24'h370000, 1'b0, 24'h0, CLS_BRANCH, 4'h2, 2'h1},
    '{24'h010000, 1'b0, 24'h0, CLS_INDIRECT, 4'h2, 2'h1},
    '{24'h030000, 1'b0, 24'h0, CLS_INDIRECT, 4'h2, 2'h1},
    '{24'hBA0000, 1'b0, 24'h0, CLS_TABLE, 4'h2, 2'h1},
    '{24'hBB0000, 1'b0, 24'h0, CLS_TABLE, 4'h2, 2'h1},
    '{24'h060000, 1'b0, 24'h0, CLS_RETURN, 4'h3, 2'h1},
    '{24'h070000, 1'b0, 24'h0, CLS_RETURN, 4'h3, 2'h1},
    '{24'hE60000, 1'b0, 24'h0, CLS_SKIP, 4'h1, 2'h1},
    '{24'hE60000, 1'b1, 24'h100000, CLS_SKIP, 4'h2, 2'h2},
    '{24'hE60000, 1'b1, 24'h020000, CLS_SKIP, 4'h3, 2'h3},
    '{24'hBE0000, 1'b0, 24'h0, CLS_DMOVE, 4'h2, 2'h1},
    '{24'h000000, 1'b0, 24'h0, CLS_NOP, 4'h1, 2'h1}};
  // last row is a nop class word: flags must hold although write is requested
  localparam ict_flag_t FLAGS [5] = '{
    '{5'h1F, 1'b0, 8'h10, 5'h1F}, '{5'h01, 1'b1, 8'h10, 5'h01},
    '{5'h00, 1'b1, 8'h10, 5'h00}, '{5'h01, 1'b1, 8'h10, 5'h00},
    '{5'h1F, 1'b0, 8'h00, 5'h00}};
  localparam int LW [6] = '{16, 1, 4, 5, 8, 14};

  logic        ref_clk, resetn, clkEn, condTrue, flagWe, stickyZ;
  logic [4:0]  resVec;
  logic [23:0] fetchWord, nextWord;
  logic        fetchValid, fetchReady, pcAdvance, execValid, nopSlot, illegalOp;
  logic [1:0]  pcAdvanceWords;
  ict_class_t  execClass;
  logic [47:0] execWord;
  logic [3:0]  bitSelectorField, workRegIdx;
  logic [12:0] fileAddr;
  logic [15:0] litValue;
  logic        accSel, accWritebackDest;
  logic [22:0] programAddressLiteral;
  logic        carryFlag, digitCarryFlag, negFlag, overflowFlag, zeroFlag;
  int          fails, checked;

  ict_decode dut (.ref_clk, .resetn, .clkEn, .fetchWord, .fetchValid, .nextWord, .condTrue,
    .flagWe, .resCarry(resVec[4]), .resDigitCarry(resVec[3]), .resNeg(resVec[2]),
    .resOverflow(resVec[1]), .resZero(resVec[0]), .stickyZ, .fetchReady, .pcAdvance,
    .pcAdvanceWords, .execValid, .execClass, .execWord, .nopSlot, .illegalOp,
    .bitSelectorField, .fileAddr, .litValue, .accSel, .accWritebackDest, .workRegIdx,
    .programAddressLiteral, .carryFlag, .digitCarryFlag, .negFlag, .overflowFlag, .zeroFlag);
  ict_fetch_model fm (.ref_clk, .fetchReady, .fetchWord, .fetchValid, .nextWord);

  always #4 ref_clk = ~ref_clk;

  task automatic tally_and_finish();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one word through issue and fill; counts are gathered at falling edges
  task automatic run_instr(input logic [23:0] w, input logic ct, input logic [23:0] nx,
                           output int cyc, output int nops, output int rdyLow,
                           output logic [1:0] wds, output ict_class_t cls);
    cyc = 0;
    nops = 0;
    rdyLow = 0;
    wds = 2'h0;
    // never an expected class, so a missing issue cannot pass
    cls = CLS_DOUBLE;
    condTrue = ct;
    fm.present(w, nx);
    fm.release_bus();
    condTrue = 1'b0;
    for (int i = 1; i <= 8 && cyc == 0; i++) begin
      if (execValid === 1'b1) cls = execClass;
      if (nopSlot === 1'b1) nops++;
      if (fetchReady === 1'b0) rdyLow++;
      if (pcAdvance === 1'b1) begin
        cyc = i;
        wds = pcAdvanceWords;
      end
      @(negedge ref_clk);
    end
    if (cyc == 0) begin
      fails++;
      tally_and_finish();
    end
  endtask

  initial begin
    int          cyc, nops, rdy;
    logic [1:0]  wds;
    ict_class_t  cls;
    logic [23:0] bad [4];
    ref_clk = 1'b0;
    resetn = 1'b0;
    clkEn = 1'b1;
    condTrue = 1'b0;
    flagWe = 1'b0;
    stickyZ = 1'b0;
    resVec = 5'h00;
    fails = 0;
    checked = 0;
    repeat (20) @(negedge ref_clk);
    `CHK({fetchReady, execValid, pcAdvance, nopSlot, illegalOp}, 5'h10);
    `CHK({execClass, carryFlag, zeroFlag}, {CLS_NOP, 2'h0});
    resetn = 1'b1;
    @(negedge ref_clk);
    foreach (ROWS[k]) begin
      run_instr(ROWS[k].w, ROWS[k].ct, ROWS[k].nx, cyc, nops, rdy, wds, cls);
      `CHK(cls, ROWS[k].cls);
      `CHK(4'(cyc), ROWS[k].cyc);
      `CHK(wds, ROWS[k].wds);
      `CHK(4'(nops), ROWS[k].cyc - 4'h1);
      `CHK(4'(rdy), ROWS[k].cyc - 4'h1);
    end
    foreach (LW[k]) begin
      run_instr({8'h10 | 8'(k), 16'hDFFF}, 1'b0, 24'h0, cyc, nops, rdy, wds, cls);
      `CHK(litValue, 16'hDFFF & (16'hFFFF >> (16 - LW[k])));
      `CHK({bitSelectorField, fileAddr}, {4'hD, 13'h1FFF});
      `CHK({accSel, accWritebackDest, workRegIdx}, 6'h3F);
    end
    run_instr(24'h102000, 1'b0, 24'h0, cyc, nops, rdy, wds, cls);
    `CHK({accSel, accWritebackDest, workRegIdx, fileAddr}, 19'h00000);
    fm.present(24'h021234, 24'h0);
    `CHK({pcAdvance, execValid}, 2'h2);
    fm.present(24'h000055, 24'h0);
    `CHK({execValid, execClass}, {1'b1, CLS_DOUBLE});
    `CHK(execWord, 48'h021234000055);
    `CHK(programAddressLiteral, 23'h551234);
    fm.release_bus();
    @(negedge ref_clk);
    `CHK(execValid, 1'b0);
    bad = '{24'h041234, 24'h010000, 24'h021235, 24'h000000};
    for (int k = 0; k < 4; k += 2) begin
      fm.present(bad[k], 24'h0);
      fm.present(bad[k + 1], 24'h0);
      `CHK({illegalOp, execValid}, 2'h2);
      fm.release_bus();
      @(negedge ref_clk);
    end
    flagWe = 1'b1;
    foreach (FLAGS[k]) begin
      resVec = FLAGS[k].r;
      stickyZ = FLAGS[k].s;
      run_instr({FLAGS[k].op, 16'h0}, 1'b0, 24'h0, cyc, nops, rdy, wds, cls);
      `CHK({carryFlag, digitCarryFlag, negFlag, overflowFlag, zeroFlag}, FLAGS[k].e);
    end
    flagWe = 1'b0;
    // frozen clock enable must hold the fill where it stands
    fm.present(24'h060000, 24'h0);
    fm.release_bus();
    clkEn = 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK({execValid, fetchReady, nopSlot}, 3'h4);
    clkEn = 1'b1;
    @(negedge ref_clk);
    `CHK({nopSlot, pcAdvance, fetchReady}, 3'h4);
    @(negedge ref_clk);
    `CHK({nopSlot, pcAdvance, fetchReady}, 3'h7);
    @(negedge ref_clk);
    fm.present(24'h070000, 24'h0);
    fm.release_bus();
    resetn = 1'b0;
    @(negedge ref_clk);
    resetn = 1'b1;
    `CHK({fetchReady, nopSlot, pcAdvance}, 3'h4);
    @(negedge ref_clk);
    tally_and_finish();
  end
endmodule // tb_top
